// [hdl/fault_history_recorder.sv]
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "fault_history_recorder_map.svh"

module fault_history_recorder
(
	// Clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          nrst,
	// AHB-Lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output      logic                          hreadyout,
	output      logic [31:0]                   hrdata,
	output      logic                          hresp,
	// Fault event from drive logic
	input  wire logic                          faultStrobe,
	input  wire logic [15:0]                   faultCode,
	// Drive quantities
	input  wire logic [15:0]                   outFreq,
	input  wire logic [15:0]                   outCurrent,
	input  wire logic [15:0]                   outVoltage,
	input  wire logic [15:0]                   motorSpeed,
	input  wire logic [15:0]                   dcBusVoltage,
	input  wire logic [15:0]                   outTorque,
	input  wire logic [15:0]                   targetFreq,
	input  wire logic [15:0]                   maxTemp,
	input  wire logic [15:0]                   runHours,
	// Drive condition
	input  wire logic                          runCmd,
	input  wire fault_history_pkg::control_mode_t controlMode,
	input  wire fault_history_pkg::run_phase_t runPhase,
	input  wire logic                          regenerating,
	input  wire fault_history_pkg::limiter_t   limiter,
	// Reset sources
	input  wire logic                          panelResetKey,
	input  wire logic                          terminalResetPin,
	input  wire logic                          busResetCmd,
	// Status outputs
	output      logic                          faultActive,
	output      logic                          irq
);
	import fault_history_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [4:0] memIndex(input logic [7:0] a);
		logic [7:0] d;
		d = a - `FHR_OFS_HIST;
		return d[6:2];
	endfunction

	function automatic logic isMemAddr(input logic [7:0] a);
		return (a >= `FHR_OFS_HIST) && (a < `FHR_OFS_HIST_END);
	endfunction

	function automatic logic pinRise(input logic s2, input logic s3,
		input logic level);
		return (s2 == s3) && s2 && !level;
	endfunction

	// ==========================================================
	// History memory
	fault_mem_if memBus ();

	fault_history_mem #(
		.SLOTS (`FHR_SLOTS),
		.WORDS (`FHR_SNAP_WORDS)
	) u_mem (
		.clk_sys (clk_sys),
		.port    (memBus.store)
	);

	recorder_state_t s;
	recorder_state_t next_s;

	logic [15:0] commandWord;
	logic [15:0] conditionWord;

	assign commandWord   = {12'h000, 3'h0, runCmd}; // [R4]
	assign conditionWord = {limiter, // [R8]
		3'h0, regenerating, // [R7]
		runPhase, // [R6]
		controlMode}; // [R5]

	assign memBus.push       = faultStrobe; // [R1]
	assign memBus.code       = faultCode;
	assign memBus.snapIn[0]  = outFreq; // [R2]
	assign memBus.snapIn[1]  = outCurrent;
	assign memBus.snapIn[2]  = outVoltage;
	assign memBus.snapIn[3]  = motorSpeed;
	assign memBus.snapIn[4]  = dcBusVoltage;
	assign memBus.snapIn[5]  = outTorque;
	assign memBus.snapIn[6]  = targetFreq;
	assign memBus.snapIn[7]  = maxTemp;
	assign memBus.snapIn[8]  = commandWord;
	assign memBus.snapIn[9]  = conditionWord;
	assign memBus.snapIn[10] = runHours; // [R3]
	assign memBus.rdIdx      = s.rdIdx;

	// ==========================================================
	// Next state
	always_comb
	begin
		logic       keyRise;
		logic       termRise;
		logic       panelClr;
		logic       termClr;
		logic       busClr;
		logic       anyClr;
		logic [1:0] irqSet;
		logic [1:0] irqW1c;
		logic [31:0] rd;
		keyRise  = 1'b0;
		termRise = 1'b0;
		panelClr = 1'b0;
		termClr  = 1'b0;
		busClr   = 1'b0;
		anyClr   = 1'b0;
		irqSet   = 2'h0;
		irqW1c   = 2'h0;
		rd       = 32'h00000000;
		next_s   = s;

		// Pin synchronisers and filter
		next_s.sync1 = {terminalResetPin, panelResetKey};
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		for (int b = 0; b < 2; b++)
		begin
			if (s.sync2[b] == s.sync3[b])
			begin
				next_s.pinLevel[b] = s.sync2[b];
			end
		end
		keyRise  = pinRise(s.sync2[0], s.sync3[0], s.pinLevel[0]);
		termRise = pinRise(s.sync2[1], s.sync3[1], s.pinLevel[1]);

		// Fault clear sources
		panelClr = keyRise && s.faultActive; // [R9]
		termClr  = termRise && s.faultActive && s.termResetEn
			&& (s.cmdSource == SRC_TERMINAL); // [R10]
		busClr   = busResetCmd && s.faultActive
			&& (s.cmdSource == SRC_FIELDBUS); // [R11]
		anyClr   = panelClr || termClr || busClr;

		if (panelClr)
		begin
			next_s.lastClear = CLR_PANEL;
		end
		else if (termClr)
		begin
			next_s.lastClear = CLR_TERMINAL;
		end
		else if (busClr)
		begin
			next_s.lastClear = CLR_FIELDBUS;
		end

		// New fault wins over a clear in the same cycle
		if (faultStrobe)
		begin
			next_s.faultActive = 1'b1;
		end
		else if (anyClr)
		begin
			next_s.faultActive = 1'b0; // [R9] [R10] [R11]
		end

		irqSet[`FHR_IRQ_FAULT] = faultStrobe;
		irqSet[`FHR_IRQ_CLEAR] = anyClr && !faultStrobe;

		// Bus slave
		next_s.hresp = 1'b0;
		case (s.busState)
			BUS_IDLE:
			begin
				if (hsel && htrans[1] && hready)
				begin
					next_s.addr      = haddr[7:0];
					next_s.addrHit   = (haddr[31:8] == 24'h000000)
						&& (haddr[1:0] == 2'h0);
					next_s.isWrite   = hwrite;
					next_s.rdIdx     = memIndex(haddr[7:0]);
					next_s.hreadyout = 1'b0;
					next_s.busState  = BUS_FETCH;
				end
			end
			BUS_FETCH:
			begin
				next_s.busState = BUS_REPLY;
			end
			BUS_REPLY:
			begin
				if (s.addrHit)
				begin
					if (isMemAddr(s.addr))
					begin
						rd = {16'h0000, memBus.rdData};
					end
					else
					begin
						case (s.addr)
							`FHR_OFS_CTRL:
							begin
								rd[`FHR_CTRL_SRC_LSB +: 2] = s.cmdSource;
								rd[`FHR_CTRL_TERM_EN]      = s.termResetEn;
							end
							`FHR_OFS_STATUS:
							begin
								rd[`FHR_STAT_ACTIVE]       = s.faultActive;
								rd[`FHR_STAT_CLR_LSB +: 2] = s.lastClear;
							end
							`FHR_OFS_IRQ_STAT:
							begin
								rd[1:0] = s.irqStatus;
							end
							`FHR_OFS_IRQ_MASK:
							begin
								rd[1:0] = s.irqMask;
							end
							default:
							begin
								rd = 32'h00000000;
							end
						endcase
					end
					if (s.isWrite)
					begin
						case (s.addr)
							`FHR_OFS_CTRL:
							begin
								next_s.cmdSource = cmd_source_t'(
									hwdata[`FHR_CTRL_SRC_LSB +: 2]);
								next_s.termResetEn = hwdata[`FHR_CTRL_TERM_EN];
							end
							`FHR_OFS_IRQ_STAT:
							begin
								irqW1c = hwdata[1:0];
							end
							`FHR_OFS_IRQ_MASK:
							begin
								next_s.irqMask = hwdata[1:0];
							end
							default:
							begin
								irqW1c = 2'h0;
							end
						endcase
					end
				end
				next_s.hrdata    = s.isWrite ? 32'h00000000 : rd;
				next_s.hreadyout = 1'b1;
				next_s.busState  = BUS_IDLE;
			end
			default:
			begin
				next_s.hreadyout = 1'b1;
				next_s.busState  = BUS_IDLE;
			end
		endcase

		// Sticky interrupt status, set beats clear
		next_s.irqStatus = (s.irqStatus & ~irqW1c) | irqSet;
		next_s.irq       = |(next_s.irqStatus & s.irqMask);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			s.busState    <= BUS_IDLE;
			s.addr        <= 8'h00;
			s.addrHit     <= 1'b0;
			s.isWrite     <= 1'b0;
			s.hreadyout   <= 1'b1;
			s.hrdata      <= 32'h00000000;
			s.hresp       <= 1'b0;
			s.cmdSource   <= SRC_PANEL;
			s.termResetEn <= `FHR_RST_TERM_EN;
			s.faultActive <= 1'b0; // [R14]
			s.lastClear   <= CLR_NONE;
			s.irqStatus   <= 2'h0;
			s.irqMask     <= `FHR_RST_MASK;
			s.irq         <= 1'b0;
			s.sync1       <= 2'h0;
			s.sync2       <= 2'h0;
			s.sync3       <= 2'h0;
			s.pinLevel    <= 2'h0;
			s.rdIdx       <= 5'h00;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign hreadyout   = s.hreadyout;
	assign hrdata      = s.hrdata;
	assign hresp       = s.hresp;
	assign faultActive = s.faultActive;
	assign irq         = s.irq;

endmodule

// [hdl/fault_history_recorder_map.svh]
// Contract
// R1 - Keep the newest fault code plus seven older codes shifting behind it.
// R2 - Fault latches freq, current, voltages, speed, torque, target, temp.
// R3 - Snapshot also holds running hours and hours since the prior fault.
// R4 - Command word lowest digit: 0 stop, 1 run; other digits read zero.
// R5 - Mode digit: 0 V/F, 1-2 vector speed, 3-4 torque, 5 V/F separation.
// R6 - Phase digit: 0 off, 1 accelerate, 2 stop, 3 reduce, 4 steady.
// R7 - Regen digit: 0 motoring, 1 generating at the moment of the fault.
// R8 - Limiter digit: 0 none, 1 overcurrent, 2 overvoltage, 3 undervoltage.
// R9 - Panel stop/reset key clears the fault while a fault is shown.
// R10 - Under terminal control, an enabled reset terminal clears the fault.
// R11 - Under fieldbus control, a host reset command clears the fault.
// R12 - Wait five minutes after overload or overheat trips before reset; the recorder applies no wait and clears at once.
// R13 - Under terminal control the run command is withdrawn before reset; the terminal clear does not check runCmd.
// R14 - Power-on reset clears the active fault but keeps history and snapshot.
`ifndef FAULT_HISTORY_RECORDER_MAP_SVH
`define FAULT_HISTORY_RECORDER_MAP_SVH

// ==========================================================
// Memory layout
`define FHR_SLOTS        8
`define FHR_CODE_W       16
`define FHR_SNAP_IN      11
`define FHR_SNAP_WORDS   12
`define FHR_SNAP_HOURS   10
`define FHR_IDX_W        5

// ==========================================================
// Register offsets
`define FHR_OFS_CTRL     8'h00
`define FHR_OFS_STATUS   8'h04
`define FHR_OFS_IRQ_STAT 8'h08
`define FHR_OFS_IRQ_MASK 8'h0C
`define FHR_OFS_HIST     8'h40
`define FHR_OFS_HIST_END 8'h90

// ==========================================================
// Field positions
`define FHR_CTRL_SRC_LSB 0
`define FHR_CTRL_TERM_EN 2
`define FHR_STAT_ACTIVE  0
`define FHR_STAT_CLR_LSB 1
`define FHR_IRQ_FAULT    0
`define FHR_IRQ_CLEAR    1

// ==========================================================
// Reset values
`define FHR_RST_MASK     2'h0
`define FHR_RST_TERM_EN  1'b0

`endif

// [hdl/fault_history_pkg.sv]
package fault_history_pkg;

	// ==========================================================
	// Captured digit encodings
	typedef enum logic [3:0]
	{
		MODE_VF         = 4'h0,
		MODE_OL_SPEED   = 4'h1,
		MODE_CL_SPEED   = 4'h2,
		MODE_OL_TORQUE  = 4'h3,
		MODE_CL_TORQUE  = 4'h4,
		MODE_VF_SPLIT   = 4'h5
	} control_mode_t;

	typedef enum logic [3:0]
	{
		PHASE_OFF       = 4'h0,
		PHASE_ACCEL     = 4'h1,
		PHASE_STOP_DEC  = 4'h2,
		PHASE_REDUCE    = 4'h3,
		PHASE_STEADY    = 4'h4
	} run_phase_t;

	typedef enum logic [3:0]
	{
		LIMIT_NONE      = 4'h0,
		LIMIT_OVERCUR   = 4'h1,
		LIMIT_OVERVOLT  = 4'h2,
		LIMIT_UNDERVOLT = 4'h3
	} limiter_t;

	// ==========================================================
	// Command sources and clear causes
	typedef enum logic [1:0]
	{
		SRC_PANEL       = 2'h0,
		SRC_TERMINAL    = 2'h1,
		SRC_FIELDBUS    = 2'h2
	} cmd_source_t;

	typedef enum logic [1:0]
	{
		CLR_NONE        = 2'h0,
		CLR_PANEL       = 2'h1,
		CLR_TERMINAL    = 2'h2,
		CLR_FIELDBUS    = 2'h3
	} clear_src_t;

	// ==========================================================
	// Bus state machine
	typedef enum logic [2:0]
	{
		BUS_IDLE        = 3'b001,
		BUS_FETCH       = 3'b010,
		BUS_REPLY       = 3'b100
	} bus_state_t;

	typedef struct packed
	{
		bus_state_t  busState;
		logic [7:0]  addr;
		logic        addrHit;
		logic        isWrite;
		logic        hreadyout;
		logic [31:0] hrdata;
		logic        hresp;
		cmd_source_t cmdSource;
		logic        termResetEn;
		logic        faultActive;
		clear_src_t  lastClear;
		logic [1:0]  irqStatus;
		logic [1:0]  irqMask;
		logic        irq;
		logic [1:0]  sync1;
		logic [1:0]  sync2;
		logic [1:0]  sync3;
		logic [1:0]  pinLevel;
		logic [4:0]  rdIdx;
	} recorder_state_t;

endpackage

// [hdl/fault_mem_if.sv]
`timescale 1ns/1ps
`include "fault_history_recorder_map.svh"

interface fault_mem_if;
	logic                                   push;
	logic [`FHR_CODE_W-1:0]                 code;
	logic [`FHR_SNAP_IN-1:0][`FHR_CODE_W-1:0] snapIn;
	logic [`FHR_IDX_W-1:0]                  rdIdx;
	logic [`FHR_CODE_W-1:0]                 rdData;

	modport store (input push, input code, input snapIn, input rdIdx,
		output rdData);
	modport feed (output push, output code, output snapIn, output rdIdx,
		input rdData);
endinterface

// [hdl/fault_history_mem.sv]
`timescale 1ns/1ps
`include "fault_history_recorder_map.svh"

module fault_history_mem
#(
	parameter int SLOTS = `FHR_SLOTS,
	parameter int WORDS = `FHR_SNAP_WORDS
)
(
	// Clock
	input wire logic clk_sys,
	// Store port
	fault_mem_if.store port
);

	// ==========================================================
	// Parameter check
	if (SLOTS < 2 || WORDS != `FHR_SNAP_WORDS ||
		SLOTS + WORDS > (1 << `FHR_IDX_W))
	begin : g_check
		$error("fault_history_mem: unsupported SLOTS or WORDS");
	end

	// ==========================================================
	// State, deliberately without reset so it survives power-on reset
	typedef struct packed
	{
		logic [SLOTS-1:0][`FHR_CODE_W-1:0] codes;
		logic [WORDS-1:0][`FHR_CODE_W-1:0] snap;
		logic [`FHR_CODE_W-1:0]            rdData;
	} mem_state_t;

	mem_state_t s;
	mem_state_t next_s;

	always_comb
	begin
		int k;
		k = int'(port.rdIdx);
		next_s = s;
		if (port.push)
		begin
			next_s.codes[0] = port.code; // [R1]
			for (int i = 1; i < SLOTS; i++)
			begin
				next_s.codes[i] = s.codes[i-1]; // [R1]
			end
			for (int i = 0; i < `FHR_SNAP_IN; i++)
			begin
				next_s.snap[i] = port.snapIn[i]; // [R2]
			end
			next_s.snap[WORDS-1] = port.snapIn[`FHR_SNAP_HOURS]
				- s.snap[`FHR_SNAP_HOURS]; // [R3]
		end
		if (k < SLOTS)
		begin
			next_s.rdData = s.codes[k];
		end
		else if (k < SLOTS + WORDS)
		begin
			next_s.rdData = s.snap[k - SLOTS];
		end
		else
		begin
			next_s.rdData = 16'h0000;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		s <= next_s; // [R14]
	end

	assign port.rdData = s.rdData;

endmodule

// [verif/fault_history_recorder_chk.sv]
`timescale 1ns/1ps

module fault_history_recorder_chk
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// Bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	// Fault and clear sources
	input wire logic        faultStrobe,
	input wire logic        panelResetKey,
	input wire logic        terminalResetPin,
	input wire logic        busResetCmd,
	input wire logic        faultActive,
	input wire logic        irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	logic [3:0] quiet;
	logic       take;

	assign take = hsel && htrans[1] && hready && hreadyout;

	// ==========================================================
	// Cycles since a reset pin was last high
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			quiet <= 4'hF;
		else if (panelResetKey || terminalResetPin)
			quiet <= 4'h0;
		else if (quiet != 4'hF)
			quiet <= quiet + 4'h1;

	// ==========================================================
	// Assertions
	a_strobe_sets: assert property (
		faultStrobe |=> faultActive) else $error("fault not raised");
	a_no_self_set: assert property (
		!faultActive && !faultStrobe |=> !faultActive)
		else $error("fault raised without event");
	a_clear_cause: assert property (
		$fell(faultActive) |-> $past(busResetCmd) ||
		$past(busResetCmd, 2) || quiet < 4'hC)
		else $error("fault cleared without cause");
	a_panel_clears: assert property (
		($rose(panelResetKey) && faultActive) ##1 panelResetKey[*4]
		|-> ##[0:6] (!faultActive || faultStrobe))
		else $error("panel key did not clear");
	a_reset_idle: assert property (
		$rose(nrst) |-> !faultActive && !irq && hreadyout)
		else $error("outputs not idle after reset");
	a_wait_states: assert property (
		take |=> !hreadyout[*2] ##1 hreadyout)
		else $error("data phase length wrong");
	a_write_zero: assert property (
		take && hwrite |-> ##3 hrdata == 32'h0)
		else $error("write reply not zero");
	a_resp_okay: assert property (!hresp) else $error("error response");

	c_fault: cover property (faultStrobe ##2 irq);
	c_clear: cover property ($fell(faultActive));
	c_write: cover property (take && hwrite);
endmodule

bind fault_history_recorder fault_history_recorder_chk chk_i (
	.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .faultStrobe(faultStrobe),
	.panelResetKey(panelResetKey), .terminalResetPin(terminalResetPin),
	.busResetCmd(busResetCmd), .faultActive(faultActive), .irq(irq));

// [verif/fault_reset_host.sv]
`timescale 1ns/1ps

module fault_reset_host
#(
	parameter int HOLDOFF = 16
)
(
	// Clock
	input wire logic clk_sys,
	// Reset sources
	output     logic panelResetKey,
	output     logic terminalResetPin,
	output     logic busResetCmd,
	// Run command
	output     logic runCmd
);
	initial
	begin
		panelResetKey = 1'b0;
		terminalResetPin = 1'b0;
		busResetCmd = 1'b0;
		runCmd = 1'b0;
	end

	// ==========================================================
	// Source 0 panel, 1 terminal, 2 fieldbus
	task automatic fire(input int src);
		repeat (HOLDOFF) @(posedge clk_sys);
		if (src == 1)
			runCmd <= 1'b0;
		@(posedge clk_sys);
		if (src == 2)
			busResetCmd <= 1'b1;
		else if (src == 1)
			terminalResetPin <= 1'b1;
		else
			panelResetKey <= 1'b1;
		@(posedge clk_sys);
		busResetCmd <= 1'b0;
		repeat (7) @(posedge clk_sys);
		panelResetKey <= 1'b0;
		terminalResetPin <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask

	task automatic setRun(input logic v);
		@(posedge clk_sys);
		runCmd <= v;
	endtask
endmodule

// [verif/test_fault_history_recorder.sv]
`timescale 1ns/1ps
`include "fault_history_recorder_map.svh"

module test_fault_history_recorder;
	import fault_history_pkg::*;

	logic          clk_sys, nrst, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0]    htrans;
	logic [31:0]   haddr, hwdata, hrdata;
	logic [15:0]   faultCode, qty [9];
	logic          faultStrobe, runCmd, regenerating, faultActive, irq;
	logic          panelResetKey, terminalResetPin, busResetCmd;
	control_mode_t controlMode;
	run_phase_t    runPhase;
	limiter_t      limiter;
	int            n_fail, tests_run;

	assign hready = hreadyout;

	fault_history_recorder fault_history_recorder_i (
		.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .faultStrobe(faultStrobe), .faultCode(faultCode),
		.outFreq(qty[0]), .outCurrent(qty[1]), .outVoltage(qty[2]),
		.motorSpeed(qty[3]), .dcBusVoltage(qty[4]), .outTorque(qty[5]),
		.targetFreq(qty[6]), .maxTemp(qty[7]), .runHours(qty[8]),
		.runCmd(runCmd), .controlMode(controlMode), .runPhase(runPhase),
		.regenerating(regenerating), .limiter(limiter),
		.panelResetKey(panelResetKey), .terminalResetPin(terminalResetPin),
		.busResetCmd(busResetCmd), .faultActive(faultActive), .irq(irq));

	fault_reset_host fault_reset_host_i (
		.clk_sys(clk_sys), .panelResetKey(panelResetKey),
		.terminalResetPin(terminalResetPin), .busResetCmd(busResetCmd),
		.runCmd(runCmd));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// Checking and bus tasks
	task summarize();
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task check(input string n, input logic [31:0] seen, input logic [31:0] e);
		tests_run++;
		if (seen !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, seen);
		end
	endtask

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		check(n, q, e);
	endtask

	task fault(input int k);
		@(posedge clk_sys);
		faultStrobe <= 1'b1;
		faultCode <= 16'h0A00 + 16'(k);
		for (int j = 0; j < 9; j++)
			qty[j] <= {4'(j + 1), 12'(k)};
		controlMode <= control_mode_t'(k % 6);
		runPhase <= run_phase_t'(k % 5);
		regenerating <= k[0];
		limiter <= limiter_t'(k % 4);
		@(posedge clk_sys);
		faultStrobe <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check("faultActive", faultActive, 1);
	endtask

	// ==========================================================
	// Tests
	initial
	begin
		{nrst, hsel, hwrite, faultStrobe, regenerating} = 5'h0;
		{htrans, haddr, hwdata, faultCode} = 82'h0;
		controlMode = MODE_VF;
		runPhase = PHASE_OFF;
		limiter = LIMIT_NONE;
		for (int j = 0; j < 9; j++)
			qty[j] = 16'h0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		rd("ctrl", `FHR_OFS_CTRL, 0);
		rd("status", `FHR_OFS_STATUS, 0);
		rd("mask", `FHR_OFS_IRQ_MASK, 0);
		rd("unmapped", 8'h20, 0);
		wr(`FHR_OFS_IRQ_MASK, 3);
		rd("mask", `FHR_OFS_IRQ_MASK, 3);
		for (int k = 1; k < 10; k++)
		begin
			fault_reset_host_i.setRun(k[1]);
			fault(k);
			rd("newest", `FHR_OFS_HIST, 32'h0A00 + 32'(k));
			rd("cmd", `FHR_OFS_HIST + 8'h40, 32'(k[1]));
			rd("cond", `FHR_OFS_HIST + 8'h44, {16'h0, 4'(k % 4), 3'h0,
				1'(k % 2), 4'(k % 5), 4'(k % 6)});
		end
		for (int i = 0; i < 8; i++)
			rd("hist", `FHR_OFS_HIST + 8'(4 * i), 32'h0A09 - 32'(i));
		for (int j = 0; j < 9; j++)
			rd("snap", `FHR_OFS_HIST + 8'(j < 8 ? 32 + 4 * j : 72),
				{16'h0, 4'(j + 1), 12'h009});
		rd("interval", `FHR_OFS_HIST + 8'h4C, 1);
		check("irq", irq, 1);
		for (int s = 0; s < 3; s++)
		begin
			fault(s);
			wr(`FHR_OFS_CTRL, s);
			fault_reset_host_i.fire(1);
			if (s != 2)
				fault_reset_host_i.fire(2);
			check("held", faultActive, 1);
			wr(`FHR_OFS_CTRL, s | 4);
			fault_reset_host_i.fire(s);
			check("cleared", faultActive, 0);
			rd("status", `FHR_OFS_STATUS, (s + 1) << 1);
		end
		rd("irqstat", `FHR_OFS_IRQ_STAT, 3);
		wr(`FHR_OFS_IRQ_MASK, 0);
		repeat (2) @(posedge clk_sys);
		check("irq", irq, 0);
		wr(`FHR_OFS_IRQ_STAT, 3);
		rd("irqstat", `FHR_OFS_IRQ_STAT, 0);
		wr(`FHR_OFS_IRQ_MASK, 2);
		fault(5);
		repeat (2) @(posedge clk_sys);
		check("irq", irq, 0);
		fault_reset_host_i.fire(0);
		check("irq", irq, 1);
		wr(`FHR_OFS_STATUS, 0);
		rd("status", `FHR_OFS_STATUS, 2);
		wr(`FHR_OFS_HIST, 0);
		rd("newest", `FHR_OFS_HIST, 32'h0A05);
		fault(6);
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		check("faultActive", faultActive, 0);
		rd("newest", `FHR_OFS_HIST, 32'h0A06);
		rd("snap", `FHR_OFS_HIST + 8'h20, 32'h1006);
		summarize();
	end

	initial
	begin
		#500000;
		n_fail++;
		summarize();
	end
endmodule
